// [pkg/rx_trunk_status_regs.vh]
// Constants for the receive trunk status word reporter
`ifndef RX_TRUNK_STATUS_REGS_VH
`define RX_TRUNK_STATUS_REGS_VH

// ****************************************
// Control stream channel numbers
// ****************************************
`define CH_ALIGN_WORD 5'h10
`define CH_NONALIGN_WORD 5'h11
`define CH_SYNC_ALARM_WORD 5'h12
`define CH_PHASE_WORD 5'h13
`define CH_CRC_COUNT_WORD 5'h14
`define CH_CRC_MF_WORD 5'h15

// ****************************************
// Field positions and thresholds
// ****************************************
`define BIT_FRAME_SYNC_LOST 7
`define BIT_MF_SYNC_LOST 6
`define BIT_FAS_ERROR_TOGGLE 5
`define BIT_SLIP_TOGGLE 4
`define BIT_RX_ALL_ONES 3
`define BIT_RX_SIG_ALL_ONES 2
`define BIT_EXT_STATUS 1
`define FAS_ERROR_THRESHOLD 5'h10
`define PHASE_WRAP_HI 8'hf8
`define PHASE_WRAP_LO 8'h08
`define PHASE_HALF 8'h80
`define RESET_WORD 8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_KHZ 24'd10000
`define ONE_SEC_MS 24'd1000
`define WINDOW_MARK_MS 24'd8
`define FAS_HOLDOFF_MS 24'd128
`define CRC_TIMEOUT_MS 24'd8

`endif

// [rtl/rx_trunk_status_word_reporter.v]
// Receive trunk status words serialised onto the control output stream
`timescale 1ns/1ns
`default_nettype none
`include "rx_trunk_status_regs.vh"


module rx_trunk_status_word_reporter #(
  parameter [23:0] ONE_SEC_CYCLES = `ONE_SEC_MS * `CLK_FREQ_KHZ,
  parameter [23:0] MARK_CYCLES = `WINDOW_MARK_MS * `CLK_FREQ_KHZ,
  parameter [23:0] HOLDOFF_CYCLES = `FAS_HOLDOFF_MS * `CLK_FREQ_KHZ,
  parameter [23:0] TIMEOUT_CYCLES = `CRC_TIMEOUT_MS * `CLK_FREQ_KHZ
) (
  input wire CLK_SYS,
  input wire NRST,
  input wire BP_CLK,
  input wire BP_FRAME_N,
  input wire EXT_STATUS,
  input wire [7:0] TS0_BYTE,
  input wire TS0_VALID,
  input wire TS0_ALIGN_FRAME,
  input wire FRAME_SYNC_LOST,
  input wire MULTIFRAME_SYNC_LOST,
  input wire FAS_ERROR,
  input wire SLIP_EVENT,
  input wire RX_ALL_ONES_ALARM,
  input wire RX_SIGNALLING_SLOT_ALL_ONES,
  input wire EIGHT_KHZ_OUTPUT,
  input wire CRC_ERROR,
  input wire MAINT_EN,
  input wire RX_MULTIFRAME_PULSE,
  input wire INTL_BIT_FRAME15,
  input wire INTL_BIT_FRAME13,
  input wire CRC_MF_LOCK,
  output wire CONTROL_SERIAL_OUT,
  output wire CONTROL_SERIAL_OE,
  output wire [7:0] ALIGN_WORD,
  output wire [7:0] NONALIGN_WORD,
  output wire [7:0] SYNC_ALARM_WORD,
  output wire [7:0] PHASE_WORD,
  output wire [7:0] CRC_COUNT_WORD,
  output wire [7:0] CRC_MF_WORD
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg bp_clk_meta_reg;
  reg bp_clk_sync_reg;
  reg bp_clk_prev_reg;
  reg fp_meta_reg;
  reg fp_sync_reg;
  reg xs_meta_reg;
  reg xs_sync_reg;
  wire bp_fall;
  wire frame_start;

  // Two flops per pin, a third on BP_CLK for its edge; the first (meta) stage is never looked at
  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      bp_clk_meta_reg <= 1'b0;
      bp_clk_sync_reg <= 1'b0;
      bp_clk_prev_reg <= 1'b0;
      fp_meta_reg <= 1'b1;
      fp_sync_reg <= 1'b1;
      xs_meta_reg <= 1'b0;
      xs_sync_reg <= 1'b0;
    end
    else
    begin
      bp_clk_meta_reg <= BP_CLK;
      bp_clk_sync_reg <= bp_clk_meta_reg;
      bp_clk_prev_reg <= bp_clk_sync_reg;
      fp_meta_reg <= BP_FRAME_N;
      fp_sync_reg <= fp_meta_reg;
      xs_meta_reg <= EXT_STATUS;
      xs_sync_reg <= xs_meta_reg;
    end
  end

  assign bp_fall = bp_clk_prev_reg & ~bp_clk_sync_reg;
  assign frame_start = bp_fall & ~fp_sync_reg;

  // ****************************************
  // Backplane bit position
  // ****************************************
  reg [7:0] bit_pos_reg;
  wire [7:0] bit_pos_next;

  // Frame pulse seen low at a falling edge restarts at channel 0 bit 0
  assign bit_pos_next = frame_start ? 8'h00 : bit_pos_reg + 8'h01;

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      bit_pos_reg <= 8'h00;
    else if (bp_fall)
      bit_pos_reg <= bit_pos_next;
  end

  // ****************************************
  // Timeslot 0 capture
  // ****************************************
  reg [7:0] align_word_reg;
  reg [7:0] nonalign_word_reg;

  // Frame type decides which word the byte lands in
  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      align_word_reg <= `RESET_WORD;
      nonalign_word_reg <= `RESET_WORD;
    end
    else if (TS0_VALID)
    begin
      if (TS0_ALIGN_FRAME)
        align_word_reg <= TS0_BYTE;
      else
        nonalign_word_reg <= TS0_BYTE;
    end
  end

  // ****************************************
  // Sync and alarm status
  // ****************************************
  reg frame_sync_lost_reg;
  reg frame_sync_lost_prev_reg;
  reg multiframe_sync_lost_reg;
  reg rx_all_ones_alarm_reg;
  reg rx_signalling_slot_all_ones_reg;
  reg external_status_sample_reg;
  reg slip_toggle_reg;
  reg fas_toggle_reg;
  reg [4:0] fas_count_reg;
  reg [23:0] holdoff_reg;
  wire fas_fire;

  // Levels follow their sources; toggles flip once per event
  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      frame_sync_lost_reg <= 1'b1;
      frame_sync_lost_prev_reg <= 1'b1;
      multiframe_sync_lost_reg <= 1'b1;
      rx_all_ones_alarm_reg <= 1'b0;
      rx_signalling_slot_all_ones_reg <= 1'b0;
      external_status_sample_reg <= 1'b0;
      slip_toggle_reg <= 1'b0;
    end
    else
    begin
      frame_sync_lost_reg <= FRAME_SYNC_LOST;
      frame_sync_lost_prev_reg <= frame_sync_lost_reg;
      multiframe_sync_lost_reg <= MULTIFRAME_SYNC_LOST;
      rx_all_ones_alarm_reg <= RX_ALL_ONES_ALARM;
      rx_signalling_slot_all_ones_reg <= RX_SIGNALLING_SLOT_ALL_ONES;
      if (frame_start)
        external_status_sample_reg <= xs_sync_reg;
      if (SLIP_EVENT)
        slip_toggle_reg <= ~slip_toggle_reg;
    end
  end

  // Hold-off keeps the error toggle to one flip per 128 ms
  assign fas_fire = (fas_count_reg >= `FAS_ERROR_THRESHOLD) && (holdoff_reg == 24'h000000);

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      fas_toggle_reg <= 1'b0;
      fas_count_reg <= 5'h00;
      holdoff_reg <= 24'h000000;
    end
    else
    begin
      if (fas_fire)
      begin
        fas_toggle_reg <= ~fas_toggle_reg;
        fas_count_reg <= {4'h0, FAS_ERROR}; // An error in the same cycle is kept
        holdoff_reg <= HOLDOFF_CYCLES - 24'h000001;
      end
      else
      begin
        if (FAS_ERROR && fas_count_reg < `FAS_ERROR_THRESHOLD)
          fas_count_reg <= fas_count_reg + 5'h01;
        if (holdoff_reg != 24'h000000)
          holdoff_reg <= holdoff_reg - 24'h000001;
      end
    end
  end

  // ****************************************
  // Transmit phase measurement
  // ****************************************
  reg eight_khz_prev_reg;
  reg [7:0] phase_reg;
  reg phase_ninth_bit_reg;
  wire eight_khz_rise;
  wire wrap_up;
  wire wrap_down;

  assign eight_khz_rise = EIGHT_KHZ_OUTPUT & ~eight_khz_prev_reg;
  // A jump across the frame end counts as a wrap, not as a big step
  assign wrap_up = (phase_reg >= `PHASE_WRAP_HI) && (bit_pos_reg < `PHASE_WRAP_LO);
  assign wrap_down = (phase_reg < `PHASE_WRAP_LO) && (bit_pos_reg >= `PHASE_WRAP_HI);

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      eight_khz_prev_reg <= 1'b0;
      phase_reg <= `RESET_WORD;
      phase_ninth_bit_reg <= 1'b0;
    end
    else
    begin
      eight_khz_prev_reg <= EIGHT_KHZ_OUTPUT;
      if (eight_khz_rise)
      begin
        phase_reg <= bit_pos_reg;
        if (wrap_up || wrap_down)
          phase_ninth_bit_reg <= ~phase_ninth_bit_reg;
      end
    end
  end

  // ****************************************
  // One-second window and CRC counting
  // ****************************************
  reg [23:0] sec_cnt_reg;
  reg [23:0] sec_cnt_next;
  reg one_second_window_marker_reg;
  reg [7:0] crc_count_reg;
  wire window_start;

  always @*
  begin
    if (sec_cnt_reg >= ONE_SEC_CYCLES - 24'h000001)
      sec_cnt_next = 24'h000000;
    else
      sec_cnt_next = sec_cnt_reg + 24'h000001;
  end

  // Marker falls on the cycle after its last high count
  assign window_start = (sec_cnt_reg == MARK_CYCLES - 24'h000001);

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      sec_cnt_reg <= 24'h000000;
      one_second_window_marker_reg <= 1'b1;
      crc_count_reg <= `RESET_WORD;
    end
    else
    begin
      sec_cnt_reg <= sec_cnt_next;
      one_second_window_marker_reg <= (sec_cnt_next < MARK_CYCLES);
      if (window_start && MAINT_EN)
        crc_count_reg <= {7'h00, CRC_ERROR};
      else if (CRC_ERROR)
        crc_count_reg <= crc_count_reg + 8'h01;
    end
  end

  // ****************************************
  // Checksum multiframe status
  // ****************************************
  reg crc_lock_reg;
  reg timeout_armed_reg;
  reg [23:0] timeout_cnt_reg;
  reg checksum_align_timeout_reg;
  reg intl_bit_frame15_reg;
  reg intl_bit_frame13_reg;
  wire frame_sync_found;

  assign frame_sync_found = frame_sync_lost_prev_reg & ~frame_sync_lost_reg;

  // Timeout runs only under maintenance; lock or dropping it clears the flag
  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      crc_lock_reg <= 1'b0;
      timeout_armed_reg <= 1'b0;
      timeout_cnt_reg <= 24'h000000;
      checksum_align_timeout_reg <= 1'b0;
    end
    else
    begin
      crc_lock_reg <= CRC_MF_LOCK;
      if (!MAINT_EN || CRC_MF_LOCK)
      begin
        timeout_armed_reg <= 1'b0;
        checksum_align_timeout_reg <= 1'b0;
      end
      else if (frame_sync_found)
      begin
        timeout_armed_reg <= 1'b1;
        timeout_cnt_reg <= TIMEOUT_CYCLES - 24'h000001;
      end
      else if (timeout_armed_reg)
      begin
        if (timeout_cnt_reg == 24'h000000)
        begin
          timeout_armed_reg <= 1'b0;
          checksum_align_timeout_reg <= 1'b1;
        end
        else
          timeout_cnt_reg <= timeout_cnt_reg - 24'h000001;
      end
    end
  end

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      intl_bit_frame15_reg <= 1'b0;
      intl_bit_frame13_reg <= 1'b0;
    end
    else if (RX_MULTIFRAME_PULSE)
    begin
      intl_bit_frame15_reg <= INTL_BIT_FRAME15;
      intl_bit_frame13_reg <= INTL_BIT_FRAME13;
    end
  end

  // ****************************************
  // Word assembly
  // ****************************************
  assign ALIGN_WORD = align_word_reg;
  assign NONALIGN_WORD = nonalign_word_reg;
  assign SYNC_ALARM_WORD = {frame_sync_lost_reg, multiframe_sync_lost_reg,
                            fas_toggle_reg, slip_toggle_reg, rx_all_ones_alarm_reg,
                            rx_signalling_slot_all_ones_reg,
                            external_status_sample_reg, 1'b0};
  assign PHASE_WORD = phase_reg;
  assign CRC_COUNT_WORD = crc_count_reg;
  assign CRC_MF_WORD = {intl_bit_frame15_reg, intl_bit_frame13_reg, 2'b00,
                        one_second_window_marker_reg, checksum_align_timeout_reg,
                        ~crc_lock_reg, phase_ninth_bit_reg};

  // ****************************************
  // Control stream serialiser
  // ****************************************
  reg [7:0] word_sel;
  reg [7:0] shift_reg;
  reg oe_reg;
  wire [4:0] chan_next;
  wire in_status_chan;

  assign chan_next = bit_pos_next[7:3];
  assign in_status_chan = (chan_next >= `CH_ALIGN_WORD) && (chan_next <= `CH_CRC_MF_WORD);

  // Channel picks its word; outside the status channels the line idles low
  always @*
  begin
    case (chan_next)
      `CH_ALIGN_WORD: word_sel = ALIGN_WORD;
      `CH_NONALIGN_WORD: word_sel = NONALIGN_WORD;
      `CH_SYNC_ALARM_WORD: word_sel = SYNC_ALARM_WORD;
      `CH_PHASE_WORD: word_sel = PHASE_WORD;
      `CH_CRC_COUNT_WORD: word_sel = CRC_COUNT_WORD;
      `CH_CRC_MF_WORD: word_sel = CRC_MF_WORD;
      default: word_sel = `RESET_WORD;
    endcase
  end

  // Snapshot at channel start so a word never changes mid-byte
  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      shift_reg <= `RESET_WORD;
      oe_reg <= 1'b0;
    end
    else if (bp_fall)
    begin
      if (bit_pos_next[2:0] == 3'h0)
      begin
        shift_reg <= word_sel;
        oe_reg <= in_status_chan;
      end
      else
        shift_reg <= {shift_reg[6:0], 1'b0};
    end
  end

  assign CONTROL_SERIAL_OUT = shift_reg[7];
  assign CONTROL_SERIAL_OE = oe_reg;

endmodule
`default_nettype wire

// [sim/rx_trunk_status_asserts.sv]
// Checker for the status word reporter
`timescale 1ns/1ns
`default_nettype none
module rx_trunk_status_asserts #(
  parameter [23:0] HOLDOFF_CYCLES = 24'd1280000
) (
  input wire CLK_SYS,
  input wire NRST,
  input wire [7:0] TS0_BYTE,
  input wire TS0_VALID,
  input wire TS0_ALIGN_FRAME,
  input wire FRAME_SYNC_LOST,
  input wire MULTIFRAME_SYNC_LOST,
  input wire SLIP_EVENT,
  input wire RX_ALL_ONES_ALARM,
  input wire RX_SIGNALLING_SLOT_ALL_ONES,
  input wire CRC_ERROR,
  input wire MAINT_EN,
  input wire RX_MULTIFRAME_PULSE,
  input wire INTL_BIT_FRAME15,
  input wire INTL_BIT_FRAME13,
  input wire CRC_MF_LOCK,
  input wire [7:0] ALIGN_WORD,
  input wire [7:0] NONALIGN_WORD,
  input wire [7:0] SYNC_ALARM_WORD,
  input wire [7:0] CRC_COUNT_WORD,
  input wire [7:0] CRC_MF_WORD
);
  reg [23:0] since_reg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // Cycles since the error bit moved; saturates so it cannot wrap
  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      since_reg <= HOLDOFF_CYCLES;
    else if ($changed(SYNC_ALARM_WORD[5]))
      since_reg <= 24'h1;
    else if (since_reg != HOLDOFF_CYCLES)
      since_reg <= since_reg + 24'h1;
  end
  sequence mf_pulse_s;
    RX_MULTIFRAME_PULSE ##1 1'b1;
  endsequence
  align_word_a:
    assert property (TS0_VALID && TS0_ALIGN_FRAME |=> ALIGN_WORD == $past(TS0_BYTE))
    else $error("alignment word not captured");
  nonalign_word_a:
    assert property (TS0_VALID && !TS0_ALIGN_FRAME |=> NONALIGN_WORD == $past(TS0_BYTE))
    else $error("non-alignment word not captured");
  alarm_levels_a:
    assert property (1'b1 |=> SYNC_ALARM_WORD[7] == $past(FRAME_SYNC_LOST)
      && SYNC_ALARM_WORD[6] == $past(MULTIFRAME_SYNC_LOST)
      && SYNC_ALARM_WORD[3] == $past(RX_ALL_ONES_ALARM)
      && SYNC_ALARM_WORD[2] == $past(RX_SIGNALLING_SLOT_ALL_ONES) && !SYNC_ALARM_WORD[0])
    else $error("status levels wrong");
  slip_toggle_a:
    assert property (1'b1 |=> $changed(SYNC_ALARM_WORD[4]) == $past(SLIP_EVENT))
    else $error("slip bit wrong");
  fas_spacing_a:
    assert property ($changed(SYNC_ALARM_WORD[5]) |-> since_reg >= HOLDOFF_CYCLES)
    else $error("error bit toggled too soon");
  crc_count_a:
    assert property (CRC_ERROR && !MAINT_EN |=> CRC_COUNT_WORD == $past(CRC_COUNT_WORD) + 8'h1)
    else $error("crc counter step wrong");
  timeout_clear_a:
    assert property (CRC_MF_LOCK || !MAINT_EN |=> !CRC_MF_WORD[2])
    else $error("timeout flag not cleared");
  lock_bit_a:
    assert property (1'b1 |=> CRC_MF_WORD[1] == !$past(CRC_MF_LOCK))
    else $error("lock bit wrong");
  si_capture_a:
    assert property (mf_pulse_s |-> CRC_MF_WORD[7] == $past(INTL_BIT_FRAME15)
      && CRC_MF_WORD[6] == $past(INTL_BIT_FRAME13) && CRC_MF_WORD[5:4] == 2'b00)
    else $error("frame 15/13 bits wrong");
endmodule
bind rx_trunk_status_word_reporter rx_trunk_status_asserts #(
  .HOLDOFF_CYCLES(HOLDOFF_CYCLES)
) status_chk (.*);
`default_nettype wire

// [sim/control_stream_reader.sv]
// Controller model: backplane timing and control stream capture
`timescale 1ns/1ns
`default_nettype none
module control_stream_reader (
  output logic BP_CLK,
  output logic BP_FRAME_N,
  input wire logic CONTROL_SERIAL_OUT,
  input wire logic CONTROL_SERIAL_OE,
  output logic [47:0] got
);
  logic [7:0] bc_reg = 8'h00;
  logic [7:0] pos_reg = 8'h00;
  logic [7:0] sh_reg = 8'h00;
  initial
  begin
    BP_CLK = 1'b0;
    BP_FRAME_N = 1'b1;
    got = 48'h0;
  end
  // Backplane clock runs free, 488 ns period
  always #244 BP_CLK = ~BP_CLK;
  // Frame pulse straddles the fall that opens a frame
  always @(posedge BP_CLK)
  begin
    bc_reg <= bc_reg + 8'h01;
    BP_FRAME_N <= bc_reg != 8'hff;
  end
  // Line shows the previous slot's bit at a fall, launch lags the edge
  always @(negedge BP_CLK)
  begin
    sh_reg = {sh_reg[6:0], CONTROL_SERIAL_OUT};
    if (CONTROL_SERIAL_OE && pos_reg[2:0] == 3'h7)
      got[8 * (21 - pos_reg[7:3]) +: 8] <= sh_reg;
    pos_reg <= BP_FRAME_N ? pos_reg + 8'h01 : 8'h00;
  end
endmodule
`default_nettype wire

// [sim/rx_trunk_status_word_reporter_test.sv]
// Testbench for the status word reporter
`timescale 1ns/1ns
`default_nettype none
module rx_trunk_status_word_reporter_test;
  logic CLK_SYS = 1'b0, NRST = 1'b0, EXT_STATUS = 1'b0, EIGHT_KHZ_OUTPUT = 1'b0;
  logic [7:0] TS0_BYTE = 8'h00;
  logic TS0_VALID = 1'b0, TS0_ALIGN_FRAME = 1'b0, FRAME_SYNC_LOST = 1'b1, FAS_ERROR = 1'b0;
  logic MULTIFRAME_SYNC_LOST = 1'b1, SLIP_EVENT = 1'b0, RX_ALL_ONES_ALARM = 1'b0;
  logic RX_SIGNALLING_SLOT_ALL_ONES = 1'b0, CRC_ERROR = 1'b0, MAINT_EN = 1'b0;
  logic RX_MULTIFRAME_PULSE = 1'b0, INTL_BIT_FRAME15 = 1'b0, INTL_BIT_FRAME13 = 1'b0;
  logic CRC_MF_LOCK = 1'b0;
  wire BP_CLK, BP_FRAME_N, CONTROL_SERIAL_OUT, CONTROL_SERIAL_OE;
  wire [7:0] ALIGN_WORD, NONALIGN_WORD, SYNC_ALARM_WORD, PHASE_WORD, CRC_COUNT_WORD;
  wire [7:0] CRC_MF_WORD;
  wire [47:0] got;
  int n_errors = 0, checked = 0, cyc = 0;
  logic [7:0] last_ph = 8'h00;
  // Short timers keep the run small
  rx_trunk_status_word_reporter #(.ONE_SEC_CYCLES(24'd200), .MARK_CYCLES(24'd20),
    .HOLDOFF_CYCLES(24'd50), .TIMEOUT_CYCLES(24'd20)) DUT (.*);
  control_stream_reader reader (.*);
  always #50 CLK_SYS = ~CLK_SYS;
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Back to back bytes of both frame types
  task t_ts0;
    tick(1);
    TS0_VALID <= 1'b1;
    TS0_ALIGN_FRAME <= 1'b1;
    TS0_BYTE <= 8'h9b;
    tick(1);
    TS0_ALIGN_FRAME <= 1'b0;
    TS0_BYTE <= 8'hdf;
    tick(1);
    TS0_VALID <= 1'b0;
    tick(1);
    @(negedge CLK_SYS);
    chk("align", 8'h9b, ALIGN_WORD);
    chk("nonalign", 8'hdf, NONALIGN_WORD);
  endtask
  // Levels flip both ways; a slip each time; read back on the stream
  task t_levels(input logic v, input logic [7:0] e);
    tick(1);
    FRAME_SYNC_LOST <= ~v;
    MULTIFRAME_SYNC_LOST <= v;
    RX_ALL_ONES_ALARM <= v;
    RX_SIGNALLING_SLOT_ALL_ONES <= ~v;
    EXT_STATUS <= v;
    SLIP_EVENT <= 1'b1;
    tick(1);
    SLIP_EVENT <= 1'b0;
    tick(2600);
    @(negedge CLK_SYS);
    chk("status", e, SYNC_ALARM_WORD);
    chk("ch16", 8'h9b, got[47:40]);
    chk("ch17", 8'hdf, got[39:32]);
    chk("ch18", e, got[31:24]);
    chk("ch19", last_ph, got[23:16]);
    chk("ch20", 8'h00, got[15:8]);
    // Marker runs free against the stream, so its bit is masked
    chk("ch21", 8'h02, got[7:0] & 8'hf7);
  endtask
  // Error bursts against the hold-off window
  task automatic t_fas;
    int cnt[4] = '{15, 1, 16, 0};
    logic [3:0] ex = 4'b0110;
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      FAS_ERROR <= cnt[i] != 0;
      tick(cnt[i] == 0 ? 40 : cnt[i]);
      FAS_ERROR <= 1'b0;
      tick(3);
      @(negedge CLK_SYS);
      chk("fas", {7'h0, ex[i]}, {7'h0, SYNC_ALARM_WORD[5]});
    end
  endtask
  // Counter wrap, one-second clear, marker width, timeout and lock
  task t_crc;
    int hi;
    hi = 0;
    tick(1);
    CRC_ERROR <= 1'b1;
    tick(257);
    CRC_ERROR <= 1'b0;
    tick(2);
    @(negedge CLK_SYS);
    chk("wrap", 8'h01, CRC_COUNT_WORD);
    tick(1);
    MAINT_EN <= 1'b1;
    FRAME_SYNC_LOST <= 1'b0;
    tick(210);
    @(negedge CLK_SYS);
    chk("clear", 8'h00, CRC_COUNT_WORD);
    chk("nosync", 8'h03, {6'h0, CRC_MF_WORD[2:1]});
    repeat (200)
    begin
      @(negedge CLK_SYS);
      hi += CRC_MF_WORD[3];
    end
    chk("marker", 8'd20, hi[7:0]);
    tick(1);
    CRC_MF_LOCK <= 1'b1;
    tick(2);
    @(negedge CLK_SYS);
    chk("sync", 8'h00, {6'h0, CRC_MF_WORD[2:1]});
  endtask
  // Every pair of frame 15/13 bits
  task t_si;
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      {INTL_BIT_FRAME15, INTL_BIT_FRAME13} <= i[1:0];
      RX_MULTIFRAME_PULSE <= 1'b1;
      tick(1);
      RX_MULTIFRAME_PULSE <= 1'b0;
      tick(1);
      @(negedge CLK_SYS);
      chk("si", {i[1:0], 6'h0}, {CRC_MF_WORD[7:4], 4'h0});
    end
  endtask
  // Phase taken at chosen positions; crosses the frame end both ways
  task automatic t_phase;
    logic [7:0] pos[4] = '{8'h40, 8'hfa, 8'h03, 8'hfc};
    logic [3:0] ex = 4'b0100;
    for (int i = 0; i < 4; i++)
    begin
      do
        @(negedge BP_CLK);
      while (BP_FRAME_N);
      repeat (pos[i]) @(negedge BP_CLK);
      // Position reaches the block about three cycles after the fall
      tick(4);
      EIGHT_KHZ_OUTPUT <= 1'b1;
      tick(1);
      EIGHT_KHZ_OUTPUT <= 1'b0;
      tick(2);
      @(negedge CLK_SYS);
      chk("phase", pos[i], PHASE_WORD);
      chk("ninth", {7'h0, ex[i]}, {7'h0, CRC_MF_WORD[0]});
    end
    last_ph = pos[3];
  endtask
  // Hang guard
  always @(posedge CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude;
    end
  end
  initial
  begin
    tick(16);
    NRST <= 1'b1;
    t_ts0;
    t_levels(1'b1, 8'h5a);
    t_phase;
    t_levels(1'b0, 8'h84);
    t_fas;
    t_crc;
    t_si;
    conclude;
  end
endmodule
`default_nettype wire
